// ---- design/inquiry_pkg.sv ----
// Constants shared by the identification response builder
package inquiry_pkg;

  // -------------------------------------------------------------------
  // Response layout
  // -------------------------------------------------------------------
  localparam logic [7:0] RESP_LEN = 8'h6A;
  localparam logic [6:0] VENDOR_LO = 7'h08;
  localparam logic [6:0] PRODUCT_LO = 7'h10;
  localparam logic [6:0] REVISION_LO = 7'h20;
  localparam logic [6:0] VSPEC_LO = 7'h24;
  localparam logic [6:0] RESERVED_LO = 7'h38;
  localparam logic [6:0] SERIAL_LO = 7'h60;
  localparam logic [6:0] SERIAL_END = 7'h6A;

  // -------------------------------------------------------------------
  // Fixed byte values
  // -------------------------------------------------------------------
  localparam logic [2:0] QUAL_CONNECTED = 3'h0;
  localparam logic [4:0] TYPE_SEQUENTIAL = 5'h01;
  localparam logic [7:0] UNIT_INVALID = 8'h7F;
  localparam logic removable_medium_flag = 1'b1;
  localparam logic [6:0] TYPE_MODIFIER = 7'h00;
  localparam logic [1:0] ISO_VERSION = 2'h0;
  localparam logic [2:0] ECMA_VERSION = 3'h0;
  localparam logic [2:0] ANSI_VERSION = 3'h2;
  localparam logic async_event_notify_cap = 1'b0;
  localparam logic terminate_process_cap = 1'b0;
  localparam logic [3:0] RESP_FORMAT = 4'h2;
  localparam logic [7:0] ADDITIONAL_LEN = 8'h65;
  localparam logic relative_addressing_cap = 1'b0;
  localparam logic wide32_transfer_cap = 1'b0;
  localparam logic wide16_transfer_cap = 1'b0;
  localparam logic sync_transfer_cap = 1'b1;
  localparam logic linked_command_cap = 1'b0;
  localparam logic tagged_queuing_cap = 1'b0;
  localparam logic soft_reset_cap = 1'b0;
  localparam logic [7:0] ASCII_SPACE = 8'h20;

  // -------------------------------------------------------------------
  // Register map and fields
  // -------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] VSPEC_OFS = 8'h10;
  localparam logic [7:0] SERIAL_OFS = 8'h30;
  localparam int VSPEC_WORDS = 5;
  localparam int SERIAL_WORDS = 3;
  localparam int CTRL_START = 0;
  localparam int CTRL_VPD = 1;
  localparam int CTRL_CMD_LUN = 4;
  localparam int CTRL_MSG_LUN = 8;
  localparam int CTRL_ALLOC = 16;
  localparam logic [31:0] SPACE_WORD = 32'h20202020;
  localparam logic [31:0] SERIAL_TOP_RESET = 32'h00002020;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_DRAIN = 2'b11
  } state_type;

endpackage

// ---- design/stream_fifo.sv ----
// Synchronous valid/ready FIFO for the response byte stream
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("stream_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Full and empty from pointers with a wrap bit
  assign level_o = wr_q - rd_q;
  assign in_ready_o = level_o != (AW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule // stream_fifo

// ---- design/response_table.sv ----
// Byte lookup for the standard identification response
`timescale 1ns/10ps
module response_table #(
  parameter logic [63:0] VENDOR_TEXT = "GENTAPE ",         // Arbitrary value
  parameter logic [127:0] PRODUCT_TEXT = "SEQDRIVE CFG0001", // Arbitrary value
  parameter logic [31:0] REVISION_TEXT = "0001"             // Arbitrary value
) (
  input wire logic [6:0] index_i,
  input wire logic unit_bad_i,
  input wire logic [159:0] vspec_i,
  input wire logic [79:0] serial_i,
  output logic [7:0] data_o
);
  // Field selection by byte index
  always_comb begin
    logic [6:0] off;
    off = 7'h00;
    data_o = 8'h00; // Reserved positions read zero
    if (index_i == 7'h00) begin
      data_o = unit_bad_i ? inquiry_pkg::UNIT_INVALID
             : {inquiry_pkg::QUAL_CONNECTED, inquiry_pkg::TYPE_SEQUENTIAL};
    end else if (index_i == 7'h01) begin
      data_o = {inquiry_pkg::removable_medium_flag, inquiry_pkg::TYPE_MODIFIER};
    end else if (index_i == 7'h02) begin
      data_o = {inquiry_pkg::ISO_VERSION, inquiry_pkg::ECMA_VERSION,
                inquiry_pkg::ANSI_VERSION};
    end else if (index_i == 7'h03) begin
      data_o = {inquiry_pkg::async_event_notify_cap, inquiry_pkg::terminate_process_cap,
                2'b00, inquiry_pkg::RESP_FORMAT};
    end else if (index_i == 7'h04) begin
      data_o = inquiry_pkg::ADDITIONAL_LEN;
    end else if (index_i == 7'h07) begin
      data_o = {inquiry_pkg::relative_addressing_cap, inquiry_pkg::wide32_transfer_cap,
                inquiry_pkg::wide16_transfer_cap, inquiry_pkg::sync_transfer_cap,
                inquiry_pkg::linked_command_cap, 1'b0,
                inquiry_pkg::tagged_queuing_cap, inquiry_pkg::soft_reset_cap};
    end else if (index_i >= inquiry_pkg::VENDOR_LO && index_i < inquiry_pkg::PRODUCT_LO) begin
      off = index_i - inquiry_pkg::VENDOR_LO;
      data_o = VENDOR_TEXT[8*(7-off[2:0]) +: 8];
    end else if (index_i >= inquiry_pkg::PRODUCT_LO && index_i < inquiry_pkg::REVISION_LO) begin
      off = index_i - inquiry_pkg::PRODUCT_LO;
      data_o = PRODUCT_TEXT[8*(15-off[3:0]) +: 8];
    end else if (index_i >= inquiry_pkg::REVISION_LO && index_i < inquiry_pkg::VSPEC_LO) begin
      off = index_i - inquiry_pkg::REVISION_LO;
      data_o = REVISION_TEXT[8*(3-off[1:0]) +: 8];
    end else if (index_i >= inquiry_pkg::VSPEC_LO && index_i < inquiry_pkg::RESERVED_LO) begin
      off = index_i - inquiry_pkg::VSPEC_LO;
      data_o = vspec_i[8*off[4:0] +: 8];
    end else if (index_i >= inquiry_pkg::SERIAL_LO && index_i < inquiry_pkg::SERIAL_END) begin
      off = index_i - inquiry_pkg::SERIAL_LO;
      data_o = serial_i[8*off[3:0] +: 8];
    end
  end
endmodule // response_table

// ---- design/inquiry_response_builder.sv ----
// Standard identification response generator with Wishbone control
`timescale 1ns/10ps
module inquiry_response_builder #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] resp_data_o,
  output logic resp_last_o,
  output logic resp_valid_o,
  input wire logic resp_ready_i,
  output logic busy_o
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("inquiry_response_builder: FIFO_DEPTH too small");
  end

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Word address match
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  inquiry_pkg::state_type state_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic req, wr_fire, start;
  logic [2:0] cmd_lun_q, msg_lun_q;
  logic vpd_q;
  logic [7:0] alloc_q;
  logic [31:0] vspec_q [inquiry_pkg::VSPEC_WORDS];
  logic [31:0] serial_q [inquiry_pkg::SERIAL_WORDS];
  logic done_q, vpd_err_q;
  logic [6:0] idx_q, limit_q;
  logic [7:0] sent_q;
  logic [31:0] ctrl_new;
  logic [7:0] alloc_new;
  logic [6:0] limit_new;
  logic unit_bad;
  logic [159:0] vspec_flat;
  logic [79:0] serial_flat;
  logic [7:0] rom_byte;
  logic last, push, fifo_in_ready;
  logic [8:0] fifo_out;
  logic [LW-1:0] fifo_level;
  logic set_done, set_vpd_err, clr_status;

  // -------------------------------------------------------------------
  // Wishbone slave
  // -------------------------------------------------------------------
  // Acknowledge one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_fire = req && wb_we_i && ack_q; // Write lands on the ack edge
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Read data captured with the acknowledge; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h00000000;
    end else if (req && !ack_q) begin
      rdata_q <= 32'h00000000;
      if (hit(wb_adr_i, inquiry_pkg::CTRL_OFS)) begin
        rdata_q[inquiry_pkg::CTRL_VPD] <= vpd_q;
        rdata_q[inquiry_pkg::CTRL_CMD_LUN +: 3] <= cmd_lun_q;
        rdata_q[inquiry_pkg::CTRL_MSG_LUN +: 3] <= msg_lun_q;
        rdata_q[inquiry_pkg::CTRL_ALLOC +: 8] <= alloc_q;
      end else if (hit(wb_adr_i, inquiry_pkg::STATUS_OFS)) begin
        rdata_q[0] <= busy_o;
        rdata_q[1] <= done_q;
        rdata_q[2] <= vpd_err_q;
        rdata_q[8 +: LW] <= fifo_level;
        rdata_q[23:16] <= sent_q;
      end
      for (int i = 0; i < inquiry_pkg::VSPEC_WORDS; i++) begin
        if (wb_adr_i[7:2] == inquiry_pkg::VSPEC_OFS[7:2] + 6'(i)) begin
          rdata_q <= vspec_q[i];
        end
      end
      for (int i = 0; i < inquiry_pkg::SERIAL_WORDS; i++) begin
        if (wb_adr_i[7:2] == inquiry_pkg::SERIAL_OFS[7:2] + 6'(i)) begin
          rdata_q <= serial_q[i];
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // Control register
  // -------------------------------------------------------------------
  assign ctrl_new = merge(32'h00000000, wb_dat_i, wb_sel_i);
  assign alloc_new = wb_sel_i[2] ? wb_dat_i[inquiry_pkg::CTRL_ALLOC +: 8] : alloc_q;
  assign start = wr_fire && hit(wb_adr_i, inquiry_pkg::CTRL_OFS)
                 && ctrl_new[inquiry_pkg::CTRL_START] && state_q == inquiry_pkg::ST_IDLE;

  // Command fields are frozen while a response is in flight
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vpd_q <= 1'b0;
      cmd_lun_q <= 3'h0;
      msg_lun_q <= 3'h0;
      alloc_q <= 8'h00;
    end else if (wr_fire && hit(wb_adr_i, inquiry_pkg::CTRL_OFS)
                 && state_q == inquiry_pkg::ST_IDLE) begin
      if (wb_sel_i[0]) begin
        vpd_q <= wb_dat_i[inquiry_pkg::CTRL_VPD];
        cmd_lun_q <= wb_dat_i[inquiry_pkg::CTRL_CMD_LUN +: 3];
      end
      if (wb_sel_i[1]) begin
        msg_lun_q <= wb_dat_i[inquiry_pkg::CTRL_MSG_LUN +: 3];
      end
      alloc_q <= alloc_new;
    end
  end

  // -------------------------------------------------------------------
  // Vendor specific and serial number text
  // -------------------------------------------------------------------
  // Spaces after reset; software may substitute other text
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < inquiry_pkg::VSPEC_WORDS; i++) begin
        vspec_q[i] <= inquiry_pkg::SPACE_WORD;
      end
    end else if (wr_fire) begin
      for (int i = 0; i < inquiry_pkg::VSPEC_WORDS; i++) begin
        if (wb_adr_i[7:2] == inquiry_pkg::VSPEC_OFS[7:2] + 6'(i)) begin
          vspec_q[i] <= merge(vspec_q[i], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // Serial characters, space padded until software writes them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      serial_q[0] <= inquiry_pkg::SPACE_WORD;
      serial_q[1] <= inquiry_pkg::SPACE_WORD;
      serial_q[2] <= inquiry_pkg::SERIAL_TOP_RESET;
    end else if (wr_fire) begin
      for (int i = 0; i < inquiry_pkg::SERIAL_WORDS; i++) begin
        if (wb_adr_i[7:2] == inquiry_pkg::SERIAL_OFS[7:2] + 6'(i)) begin
          serial_q[i] <= merge(serial_q[i], wb_dat_i, wb_sel_i);
        end
      end
      serial_q[2][31:16] <= 16'h0000; // Beyond byte 105
    end
  end

  assign vspec_flat = {vspec_q[4], vspec_q[3], vspec_q[2], vspec_q[1], vspec_q[0]};
  assign serial_flat = {serial_q[2][15:0], serial_q[1], serial_q[0]};

  // -------------------------------------------------------------------
  // Response bytes
  // -------------------------------------------------------------------
  assign unit_bad = (cmd_lun_q != 3'h0) || (msg_lun_q != 3'h0);

  // Field contents, reserved positions zero
  response_table u_table (
    .index_i(idx_q),
    .unit_bad_i(unit_bad),
    .vspec_i(vspec_flat),
    .serial_i(serial_flat),
    .data_o(rom_byte)
  );

  // Transfer length is the lesser of allocation and response size
  assign limit_new = (alloc_new > inquiry_pkg::RESP_LEN) ? inquiry_pkg::RESP_LEN[6:0]
                   : alloc_new[6:0];
  assign last = idx_q == limit_q - 7'h01;
  assign push = state_q == inquiry_pkg::ST_FILL && fifo_in_ready;

  // -------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------
  // Idle, fill the FIFO, wait for the stream to drain
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= inquiry_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        inquiry_pkg::ST_IDLE: begin
          if (start && !ctrl_new[inquiry_pkg::CTRL_VPD] && limit_new != 7'h00) begin
            state_q <= inquiry_pkg::ST_FILL;
          end
        end
        inquiry_pkg::ST_FILL: begin
          if (push && last) begin
            state_q <= inquiry_pkg::ST_DRAIN;
          end
        end
        inquiry_pkg::ST_DRAIN: begin
          if (fifo_level == LW'(0)) begin
            state_q <= inquiry_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= inquiry_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Byte index, limit and count of bytes queued
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      idx_q <= 7'h00;
      limit_q <= 7'h00;
      sent_q <= 8'h00;
    end else if (start) begin
      idx_q <= 7'h00;
      limit_q <= limit_new;
      sent_q <= 8'h00;
    end else if (push) begin
      idx_q <= idx_q + 7'h01;
      sent_q <= sent_q + 8'h01;
    end
  end

  // -------------------------------------------------------------------
  // Status flags
  // -------------------------------------------------------------------
  assign set_done = (start && (ctrl_new[inquiry_pkg::CTRL_VPD] || limit_new == 7'h00))
                 || (state_q == inquiry_pkg::ST_DRAIN && fifo_level == LW'(0));
  assign set_vpd_err = start && ctrl_new[inquiry_pkg::CTRL_VPD];
  assign clr_status = wr_fire && hit(wb_adr_i, inquiry_pkg::STATUS_OFS) && wb_sel_i[0];

  // Write one to clear; a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      done_q <= 1'b0;
      vpd_err_q <= 1'b0;
    end else begin
      done_q <= set_done || (done_q && !(clr_status && wb_dat_i[1]));
      vpd_err_q <= set_vpd_err || (vpd_err_q && !(clr_status && wb_dat_i[2]));
    end
  end

  assign busy_o = state_q != inquiry_pkg::ST_IDLE;

  // -------------------------------------------------------------------
  // Output stream buffer
  // -------------------------------------------------------------------
  stream_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(state_q == inquiry_pkg::ST_FILL),
    .in_ready_o(fifo_in_ready),
    .in_data_i({last, rom_byte}),
    .out_valid_o(resp_valid_o),
    .out_ready_i(resp_ready_i),
    .out_data_o(fifo_out),
    .level_o(fifo_level)
  );

  assign resp_data_o = fifo_out[7:0];
  assign resp_last_o = fifo_out[8];

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_start_std;
    start && !ctrl_new[inquiry_pkg::CTRL_VPD] && limit_new != 7'h00;
  endsequence

  sequence s_start_vpd;
    start && ctrl_new[inquiry_pkg::CTRL_VPD];
  endsequence

  a_byte0_unit: assert property ((idx_q == 7'h00 && !unit_bad) |-> rom_byte == 8'h01)
    else $error("byte 0 not sequential type for unit zero");
  a_byte0_qual: assert property ((idx_q == 7'h00 && !unit_bad) |-> rom_byte[7:5] == 3'h0)
    else $error("byte 0 qualifier not zero");
  a_byte0_bad: assert property ((idx_q == 7'h00 && unit_bad) |-> rom_byte == 8'h7F)
    else $error("byte 0 not invalid unit code");
  a_byte1_removable: assert property ((idx_q == 7'h01) |-> rom_byte == 8'h80)
    else $error("byte 1 wrong");
  a_byte2_ver: assert property ((idx_q == 7'h02) |-> rom_byte == 8'h02)
    else $error("byte 2 versions wrong");
  a_byte3_fmt: assert property ((idx_q == 7'h03) |-> rom_byte == 8'h02)
    else $error("byte 3 format wrong");
  a_byte4_len: assert property ((idx_q == 7'h04) |-> rom_byte == 8'h65)
    else $error("byte 4 length wrong");
  a_byte7_caps: assert property ((idx_q == 7'h07) |-> rom_byte == 8'h10)
    else $error("byte 7 capabilities wrong");
  a_reserved_zero: assert property ((idx_q == 7'h05 || idx_q == 7'h06
      || (idx_q >= 7'h38 && idx_q < 7'h60)) |-> rom_byte == 8'h00)
    else $error("reserved byte not zero");
  a_vendor_space: assert property ((idx_q == 7'h0F) |-> rom_byte == 8'h20)
    else $error("vendor field lacks trailing space");
  a_serial_map: assert property ((idx_q == 7'h60) |-> rom_byte == serial_q[0][7:0])
    else $error("serial first character misplaced");
  a_std_start: assert property (s_start_std |=> state_q == inquiry_pkg::ST_FILL
      && idx_q == 7'h00 && limit_q == $past(limit_new))
    else $error("standard request did not start filling");
  a_vpd_refuse: assert property (s_start_vpd |=> !busy_o && vpd_err_q && done_q)
    else $error("page request not refused");
  a_length_cap: assert property (push |-> idx_q < limit_q && limit_q <= 7'h6A)
    else $error("byte pushed beyond transfer length");
  a_zero_alloc: assert property ((start && limit_new == 7'h00) |=> !busy_o [*2])
    else $error("zero allocation transferred data");
endmodule // inquiry_response_builder

// ---- dv/initiator_model.sv ----
// Initiator model that consumes the response byte stream
`timescale 1ns/10ps
module initiator_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clr_i,
  input wire logic hold_i,
  input wire logic slow_i,
  input wire logic [7:0] resp_data_i,
  input wire logic resp_last_i,
  input wire logic resp_valid_i,
  output logic resp_ready_o
);
  logic [7:0] mem [0:127];
  logic [7:0] count_q;
  logic [7:0] last_at_q;
  logic [1:0] pace_q;
  // Ready pattern: held off, one cycle in four, or every cycle
  always_ff @(posedge clk_i) begin
    pace_q <= reset_i ? 2'h0 : pace_q + 2'h1;
    resp_ready_o <= !reset_i && !hold_i && (!slow_i || pace_q == 2'h0);
  end
  // Capture each accepted byte in arrival order
  always_ff @(posedge clk_i) begin
    if (reset_i || clr_i) begin
      count_q <= 8'h00;
      last_at_q <= 8'hFF;
    end else if (resp_valid_i && resp_ready_o) begin
      mem[count_q] <= resp_data_i;
      if (resp_last_i) last_at_q <= count_q;
      count_q <= count_q + 8'h01;
    end
  end
endmodule // initiator_model

// ---- dv/tb.sv ----
// Self-checking testbench for the identification response builder
`timescale 1ns/10ps
module tb;
  logic clk_i, reset_i, cyc, stb, we, clr, hold, slow;
  logic [3:0] sel;
  logic [7:0] adr, resp_data;
  logic [31:0] wdat, rdat, q;
  logic ack, last, valid, ready, busy;
  logic [7:0] vs [0:19];
  logic [7:0] sn [0:9];
  int miscompares = 0;
  int n_compared = 0;
  localparam logic [7:0] HDR [0:7] = '{8'h01, 8'h80, 8'h02, 8'h02, 8'h65, 8'h00, 8'h00, 8'h10};
  localparam logic [63:0] VEND = "GENTAPE ";
  localparam logic [127:0] PROD = "SEQDRIVE CFG0001";
  localparam logic [31:0] REV = "0001";
  inquiry_response_builder u_dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .resp_data_o(resp_data), .resp_last_o(last),
    .resp_valid_o(valid), .resp_ready_i(ready), .busy_o(busy));
  initiator_model u_host (.clk_i(clk_i), .reset_i(reset_i), .clr_i(clr), .hold_i(hold),
    .slow_i(slow), .resp_data_i(resp_data), .resp_last_i(last), .resp_valid_i(valid),
    .resp_ready_o(ready));
  // Clock at 25 MHz
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Compare one value and count the outcome
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  // Expected response byte at index i
  function automatic logic [7:0] eb(input int i, input logic bad);
    if (i == 0) return bad ? 8'h7F : 8'h01;
    if (i < 8) return HDR[i];
    if (i < 16) return VEND[8*(15-i) +: 8];
    if (i < 32) return PROD[8*(31-i) +: 8];
    if (i < 36) return REV[8*(35-i) +: 8];
    if (i < 56) return vs[i-36];
    if (i < 96) return 8'h00;
    return sn[i-96];
  endfunction
  // Start a response and check every byte the initiator received
  task automatic run(input logic [31:0] ctrl, input int n, input logic bad);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wb(inquiry_pkg::CTRL_OFS, 1'b1, ctrl | 32'h1);
    chk("busy out", 32'(busy), 32'(n > 0));
    while (busy !== 1'b0) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    chk("count", 32'(u_host.count_q), 32'(n));
    for (int i = 0; i < n; i++) chk("byte", 32'(u_host.mem[i]), 32'(eb(i, bad)));
    if (n > 0) chk("last", 32'(u_host.last_at_q), 32'(n - 1));
  endtask
  task automatic close_out;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    close_out;
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    reset_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0;
    sel = 4'h0;
    clr = 0; hold = 1; slow = 0;
    foreach (vs[i]) vs[i] = 8'h20;
    foreach (sn[i]) sn[i] = 8'h20;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    wb(inquiry_pkg::CTRL_OFS, 1'b0, 0); chk("ctrl rst", q, 32'h0);
    wb(inquiry_pkg::VSPEC_OFS, 1'b0, 0); chk("vspec rst", q, 32'h20202020);
    wb(8'h38, 1'b0, 0); chk("serial rst", q, inquiry_pkg::SERIAL_TOP_RESET);
    wb(8'h80, 1'b0, 0); chk("unmapped", q, 32'h0);
    // Stalled initiator: FIFO fills to its depth, then slow drain
    fork
      run(32'h00FF0000, 106, 1'b0);
      begin
        repeat (60) @(posedge clk_i);
        wb(inquiry_pkg::STATUS_OFS, 1'b0, 0);
        chk("level", {27'h0, q[12:8]}, 32'h10);
        chk("busy", {31'h0, q[0]}, 32'h1);
        hold <= 1'b0; slow <= 1'b1;
      end
    join
    wb(inquiry_pkg::STATUS_OFS, 1'b0, 0); chk("done", {19'h0, q[12:0]}, 32'h2);
    wb(inquiry_pkg::STATUS_OFS, 1'b1, 32'h2);
    wb(inquiry_pkg::STATUS_OFS, 1'b0, 0); chk("done clr", {31'h0, q[1]}, 32'h0);
    // Custom vendor-specific and serial contents, prompt initiator
    slow <= 1'b0;
    wb(8'h14, 1'b1, 32'h44434241);
    for (int i = 0; i < 4; i++) vs[4+i] = 8'h41 + 8'(i);
    wb(8'h34, 1'b1, 32'h39383736);
    for (int i = 0; i < 4; i++) sn[4+i] = 8'h36 + 8'(i);
    run(32'h006A0000, 106, 1'b0);
    // Nonzero unit in either field, truncated allocation
    run(32'h00030030, 3, 1'b1);
    run(32'h00690500, 105, 1'b1);
    run(32'h006B0000, 106, 1'b0);
    run(32'h00010000, 1, 1'b0);
    // Zero allocation and page request send nothing
    run(32'h00000000, 0, 1'b0);
    run(32'h00FF0002, 0, 1'b0);
    wb(inquiry_pkg::STATUS_OFS, 1'b0, 0); chk("refused", {29'h0, q[2:0]}, 32'h6);
    close_out;
  end
endmodule // tb
